// *** rtl/dcc_pkg.sv ***
package dcc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SL_DATA_W = 34;
  localparam int unsigned SL_ADDR_W = 10;
  localparam int unsigned SL_PAIRS = 5;
  localparam int unsigned PC_W = 11;
  localparam int unsigned DM_ADDR_W = 13;
  localparam int unsigned SLEW_W = 6;

  // register offsets
  localparam logic [11:0] CORE_CTL_ADDR = 12'h0a52;
  localparam logic [11:0] RAM_CFG_ADDR = 12'h0a53;
  localparam logic [11:0] SL_DATA_BASE = 12'h0810;
  localparam logic [11:0] SL_ADDR_BASE = 12'h0815;

  // core control field positions
  localparam int unsigned CTL_MUTED = 13;
  localparam int unsigned CTL_SLEW_MUTE = 12;
  localparam int unsigned CTL_RSVD_ZERO = 11;
  localparam int unsigned CTL_OUT_LATCH = 10;
  localparam int unsigned CTL_CLEAR_N = 9;
  localparam int unsigned CTL_MULT_ZERO = 8;
  localparam int unsigned CTL_DM_INIT = 7;
  localparam int unsigned CTL_IN_ZERO = 6;
  localparam int unsigned CTL_SL_TARGET = 5;
  localparam int unsigned CTL_SL_PARAM = 4;
  localparam int unsigned CTL_SYNC_LSB = 2;
  localparam int unsigned CTL_LEN_LSB = 0;

  // reset values, and the largest valid RAM configuration code
  localparam logic [15:0] CORE_CTL_RESET = 16'h0000;
  localparam logic [3:0] RAM_CFG_RESET = 4'hc;
  localparam logic [3:0] RAM_CFG_MAX = 4'hc;

  // program lengths in steps
  localparam logic [10:0] LEN_1536 = 11'h0600;
  localparam logic [10:0] LEN_768 = 11'h0300;
  localparam logic [10:0] LEN_384 = 11'h0180;
  localparam logic [10:0] LEN_192 = 11'h00c0;

  localparam logic [12:0] DM_WORDS = 13'h1800;
  localparam logic [5:0] SLEW_LAST = 6'h3f;
  localparam int unsigned MOD_UNIT_LSB = 9;
endpackage

// *** rtl/dcc_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_pin_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      o_rise <= (s2 == s3) && s3 && !o_level;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/dcc_mod_addr.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_mod_addr (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_cfg,
  input wire logic i_frame,
  input wire logic [12:0] i_base,
  output logic [12:0] o_addr
);
  logic [3:0] cfg_eff;
  logic [12:0] size;
  logic [12:0] offset;
  logic [13:0] sum;
  logic [13:0] wrapped;

  // codes above the largest valid one are treated as full modulo memory
  assign cfg_eff = (i_cfg > dcc_pkg::RAM_CFG_MAX) ? dcc_pkg::RAM_CFG_MAX : i_cfg;
  assign size = {cfg_eff, 9'h000};
  assign sum = {1'b0, i_base} + {1'b0, offset};
  assign wrapped = (sum >= {1'b0, size}) ? sum - {1'b0, size} : sum;

  // offset steps once per audio frame and stays inside the region
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      offset <= 13'h0000;
    end else if (size == 13'h0000 || offset >= size) begin
      offset <= 13'h0000;
    end else if (i_frame) begin
      offset <= (offset + 13'h0001 >= size) ? 13'h0000 : offset + 13'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr <= 13'h0000;
    end else if (i_base < size) begin
      o_addr <= wrapped[12:0];
    end else begin
      o_addr <= i_base;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dcc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_core (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [33:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_in_lrclk,
  input wire logic i_out_lrclk,
  output logic [10:0] o_pc,
  output logic o_frame_start,
  output logic o_prog_end,
  output logic o_out_latch,
  output logic o_core_clear_n,
  output logic o_mult_zero,
  output logic o_in_port_zero,
  input wire logic [12:0] i_dm_base,
  output logic [12:0] o_dm_addr,
  output logic o_dm_fill_we,
  output logic [12:0] o_dm_fill_addr,
  output logic o_slew_we,
  output logic [5:0] o_slew_idx,
  output logic o_slew_zero,
  output logic o_sl_we,
  output logic o_sl_to_target,
  output logic [9:0] o_sl_addr,
  output logic [33:0] o_sl_data
);
  typedef enum logic [1:0] {SL_IDLE, SL_SEND} dcc_sl_state_t;

  logic [15:0] ctl;
  logic [3:0] ram_cfg;
  logic muted, wr_ctl, rd_ctl;
  logic in_rise, out_rise, sync_pulse;
  logic [2:0] sync_cnt, sync_mask;
  logic [10:0] prog_len;
  logic running, fill_busy, fill_done;
  logic slew_busy, slew_state, slew_done;
  logic [33:0] sl_data [dcc_pkg::SL_PAIRS];
  logic [9:0] sl_addr [dcc_pkg::SL_PAIRS];
  logic [4:0] sl_written;
  logic [4:0] sl_wr_hit;
  dcc_sl_state_t sl_state;
  logic [2:0] sl_idx;
  logic sl_target, sl_done;

  assign wr_ctl = i_reg_wr && (i_reg_addr == dcc_pkg::CORE_CTL_ADDR);
  assign rd_ctl = i_reg_rd && (i_reg_addr == dcc_pkg::CORE_CTL_ADDR);

  dcc_pin_sync u_in_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_in_lrclk),
    .o_level(),
    .o_rise(in_rise)
  );

  dcc_pin_sync u_out_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_out_lrclk),
    .o_level(),
    .o_rise(out_rise)
  );

  // control register; hardware clears of self-clearing bits lose to a host write
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl <= dcc_pkg::CORE_CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= i_reg_wdata[15:0];
      ctl[15:13] <= 3'b000;
      ctl[dcc_pkg::CTL_RSVD_ZERO] <= 1'b0;
    end else begin
      if (fill_done) begin
        ctl[dcc_pkg::CTL_DM_INIT] <= 1'b0;
      end
      if (sl_done && sl_target) begin
        ctl[dcc_pkg::CTL_SL_TARGET] <= 1'b0;
      end
      if (sl_done && !sl_target) begin
        ctl[dcc_pkg::CTL_SL_PARAM] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ram_cfg <= dcc_pkg::RAM_CFG_RESET;
    end else if (i_reg_wr && i_reg_addr == dcc_pkg::RAM_CFG_ADDR) begin
      ram_cfg <= i_reg_wdata[3:0];
    end
  end

  // sticky muted flag; a completion in the read cycle survives the read
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      muted <= 1'b0;
    end else if (slew_done) begin
      muted <= 1'b1;
    end else if (rd_ctl) begin
      muted <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (rd_ctl) begin
        o_reg_rdata <= {2'b00, muted, ctl[12:0]};
      end else if (i_reg_rd && i_reg_addr == dcc_pkg::RAM_CFG_ADDR) begin
        o_reg_rdata <= {12'h000, ram_cfg};
      end else if (i_reg_rd) begin
        o_reg_rdata <= 16'h0000;
      end
    end
  end

  // static controls, straight from the register
  assign o_core_clear_n = ctl[dcc_pkg::CTL_CLEAR_N];
  assign o_mult_zero = ctl[dcc_pkg::CTL_MULT_ZERO];
  assign o_in_port_zero = ctl[dcc_pkg::CTL_IN_ZERO];

  // frame sync: input LRCLK rising edges divided by 1, 2, 4 or 8
  always_comb begin
    unique case (ctl[3:2])
      2'b00: sync_mask = 3'b000;
      2'b01: sync_mask = 3'b001;
      2'b10: sync_mask = 3'b011;
      2'b11: sync_mask = 3'b111;
    endcase
  end

  assign sync_pulse = in_rise && ((sync_cnt & sync_mask) == 3'b000);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_cnt <= 3'b000;
    end else if (in_rise) begin
      sync_cnt <= sync_cnt + 3'b001;
    end
  end

  always_comb begin
    unique case (ctl[1:0])
      2'b00: prog_len = dcc_pkg::LEN_1536;
      2'b01: prog_len = dcc_pkg::LEN_768;
      2'b10: prog_len = dcc_pkg::LEN_384;
      2'b11: prog_len = dcc_pkg::LEN_192;
    endcase
  end

  // program counter restarts on every frame sync and idles after the last step
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= 11'h000;
      running <= 1'b0;
      o_frame_start <= 1'b0;
      o_prog_end <= 1'b0;
    end else begin
      o_frame_start <= sync_pulse;
      o_prog_end <= 1'b0;
      if (sync_pulse) begin
        o_pc <= 11'h000;
        running <= 1'b1;
      end else if (running && o_pc >= prog_len - 11'h001) begin
        running <= 1'b0;
        o_prog_end <= 1'b1;
      end else if (running) begin
        o_pc <= o_pc + 11'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_latch <= 1'b0;
    end else if (ctl[dcc_pkg::CTL_OUT_LATCH]) begin
      o_out_latch <= out_rise;
    end else begin
      o_out_latch <= running && o_pc >= prog_len - 11'h001;
    end
  end

  dcc_mod_addr u_mod (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_cfg(ram_cfg),
    .i_frame(sync_pulse),
    .i_base(i_dm_base),
    .o_addr(o_dm_addr)
  );

  // data memory zero fill, one word per cycle
  assign fill_done = fill_busy && o_dm_fill_addr == dcc_pkg::DM_WORDS - 13'h0001;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_busy <= 1'b0;
      o_dm_fill_we <= 1'b0;
      o_dm_fill_addr <= 13'h0000;
    end else if (fill_busy) begin
      if (fill_done) begin
        fill_busy <= 1'b0;
        o_dm_fill_we <= 1'b0;
      end else begin
        o_dm_fill_addr <= o_dm_fill_addr + 13'h0001;
      end
    end else if (ctl[dcc_pkg::CTL_DM_INIT] && !wr_ctl) begin
      fill_busy <= 1'b1;
      o_dm_fill_we <= 1'b1;
      o_dm_fill_addr <= 13'h0000;
    end
  end

  // slew walk: on a change of bit 12 every entry gets its data zeroed or restored;
  // the entry's ramp settings are left alone so the ramp shape is kept
  assign slew_done = slew_busy && o_slew_idx == dcc_pkg::SLEW_LAST && o_slew_zero;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slew_busy <= 1'b0;
      slew_state <= 1'b0;
      o_slew_we <= 1'b0;
      o_slew_idx <= 6'h00;
      o_slew_zero <= 1'b0;
    end else if (slew_busy) begin
      if (o_slew_idx == dcc_pkg::SLEW_LAST) begin
        slew_busy <= 1'b0;
        o_slew_we <= 1'b0;
      end else begin
        o_slew_idx <= o_slew_idx + 6'h01;
      end
    end else if (ctl[dcc_pkg::CTL_SLEW_MUTE] != slew_state) begin
      slew_state <= ctl[dcc_pkg::CTL_SLEW_MUTE];
      slew_busy <= 1'b1;
      o_slew_we <= 1'b1;
      o_slew_idx <= 6'h00;
      o_slew_zero <= ctl[dcc_pkg::CTL_SLEW_MUTE];
    end
  end

  // safeload pairs; a new write beats the clear at the end of a transfer
  genvar g;
  generate
    for (g = 0; g < dcc_pkg::SL_PAIRS; g++) begin : g_pair
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sl_data[g] <= 34'h0_0000_0000;
          sl_addr[g] <= 10'h000;
          sl_written[g] <= 1'b0;
        end else begin
          if (i_reg_wr && i_reg_addr == dcc_pkg::SL_DATA_BASE + 12'(g)) begin
            sl_data[g] <= i_reg_wdata;
          end
          if (sl_wr_hit[g]) begin
            sl_addr[g] <= i_reg_wdata[9:0];
            sl_written[g] <= 1'b1;
          end else if (sl_done) begin
            sl_written[g] <= 1'b0;
          end
        end
      end
      assign sl_wr_hit[g] = i_reg_wr && i_reg_addr == dcc_pkg::SL_ADDR_BASE + 12'(g);
    end
  endgenerate

  // transfer starts at the next frame sync, so it lands within one frame
  assign sl_done = sl_state == SL_SEND && sl_idx == 3'(dcc_pkg::SL_PAIRS - 1);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sl_state <= SL_IDLE;
      sl_idx <= 3'b000;
      sl_target <= 1'b0;
      o_sl_we <= 1'b0;
      o_sl_to_target <= 1'b0;
      o_sl_addr <= 10'h000;
      o_sl_data <= 34'h0_0000_0000;
    end else begin
      o_sl_we <= 1'b0;
      unique case (sl_state)
        SL_IDLE: begin
          sl_idx <= 3'b000;
          if (sync_pulse && (ctl[dcc_pkg::CTL_SL_TARGET] || ctl[dcc_pkg::CTL_SL_PARAM])) begin
            sl_state <= SL_SEND;
            sl_target <= ctl[dcc_pkg::CTL_SL_TARGET];
          end
        end
        SL_SEND: begin
          o_sl_we <= sl_written[sl_idx];
          o_sl_to_target <= sl_target;
          o_sl_addr <= sl_addr[sl_idx];
          o_sl_data <= sl_data[sl_idx];
          sl_idx <= sl_idx + 3'b001;
          if (sl_done) begin
            sl_state <= SL_IDLE;
          end
        end
        default: sl_state <= SL_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/dcc_core_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_core_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic [11:0] i_reg_addr,
  input wire logic [33:0] i_reg_wdata,
  input wire logic [10:0] o_pc,
  input wire logic o_frame_start,
  input wire logic o_prog_end,
  input wire logic o_out_latch,
  input wire logic o_core_clear_n,
  input wire logic o_mult_zero,
  input wire logic o_in_port_zero,
  input wire logic [12:0] i_dm_base,
  input wire logic [12:0] o_dm_addr,
  input wire logic o_dm_fill_we,
  input wire logic [12:0] o_dm_fill_addr,
  input wire logic o_slew_we,
  input wire logic [5:0] o_slew_idx,
  input wire logic o_slew_zero,
  input wire logic o_sl_we,
  input wire logic o_sl_to_target
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic wr_ctl, wr_cfg, latch_lr;
  logic [3:0] cfg;
  logic [12:0] mod_size;
  assign wr_ctl = i_reg_wr && (i_reg_addr == dcc_pkg::CORE_CTL_ADDR);
  assign wr_cfg = i_reg_wr && (i_reg_addr == dcc_pkg::RAM_CFG_ADDR);
  assign mod_size = {cfg, 9'h000};
  // shadows follow host writes so no internal state has to be probed
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_lr <= 1'b0;
      cfg <= dcc_pkg::RAM_CFG_RESET;
    end else begin
      if (wr_ctl) latch_lr <= i_reg_wdata[10];
      if (wr_cfg) cfg <= (i_reg_wdata[3:0] > 4'hc) ? 4'hc : i_reg_wdata[3:0];
    end
  end
  AST_RESET: assert property ($rose(i_rst_n) |-> !o_core_clear_n && !o_mult_zero)
    else $error("control outputs not cleared by reset");
  AST_CLEAR: assert property (wr_ctl |=> o_core_clear_n == $past(i_reg_wdata[9]))
    else $error("clear output does not follow bit 9");
  AST_IN_ZERO: assert property (wr_ctl |=> o_in_port_zero == $past(i_reg_wdata[6]))
    else $error("input zero does not follow bit 6");
  AST_FILL_STEP: assert property (o_dm_fill_we && $past(o_dm_fill_we)
    |-> o_dm_fill_addr == $past(o_dm_fill_addr) + 13'h0001) else $error("fill address skipped");
  AST_FILL_LAST: assert property (o_dm_fill_we && o_dm_fill_addr == 13'h17ff
    |=> !o_dm_fill_we) else $error("fill ran past last word");
  AST_SLEW_STEP: assert property (o_slew_we && $past(o_slew_we)
    |-> o_slew_idx == $past(o_slew_idx) + 6'h01 && $stable(o_slew_zero)) else $error("slew walk");
  AST_PC_ZERO: assert property (o_frame_start |-> o_pc == 11'h000)
    else $error("frame start without pc zero");
  AST_PC_STEP: assert property (!o_frame_start && $past(o_pc) != 11'h000
    && $past(o_pc) < 11'h0bf |-> o_pc == $past(o_pc) + 11'h001) else $error("pc did not step");
  AST_MOD_DIRECT: assert property ($past(i_dm_base) >= mod_size && $stable(cfg)
    |-> o_dm_addr == $past(i_dm_base)) else $error("direct address was offset");
  AST_LATCH: assert property (o_out_latch && !latch_lr
    |-> o_prog_end || $past(o_prog_end)) else $error("output latch without program end");
  cover property (o_dm_fill_we && o_dm_fill_addr == 13'h17ff);
  cover property (o_slew_we && o_slew_zero);
  cover property (o_sl_we && o_sl_to_target);
endmodule
bind dcc_core dcc_core_checker dcc_core_checker_i (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .o_pc(o_pc),
  .o_frame_start(o_frame_start),
  .o_prog_end(o_prog_end),
  .o_out_latch(o_out_latch),
  .o_core_clear_n(o_core_clear_n),
  .o_mult_zero(o_mult_zero),
  .o_in_port_zero(o_in_port_zero),
  .i_dm_base(i_dm_base),
  .o_dm_addr(o_dm_addr),
  .o_dm_fill_we(o_dm_fill_we),
  .o_dm_fill_addr(o_dm_fill_addr),
  .o_slew_we(o_slew_we),
  .o_slew_idx(o_slew_idx),
  .o_slew_zero(o_slew_zero),
  .o_sl_we(o_sl_we),
  .o_sl_to_target(o_sl_to_target)
);
`default_nettype wire

// *** verification/dcc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_host (
  input wire logic i_core_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr,
  output logic o_rd,
  output logic [11:0] o_addr,
  output logic [33:0] o_wdata,
  output logic o_in_lrclk,
  output logic o_out_lrclk
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 12'h000;
    o_wdata = 34'h0000;
    o_in_lrclk = 1'b0;
    o_out_lrclk = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [33:0] d);
    @(posedge i_core_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
  endtask
  // read data counts only with its valid strobe, one cycle after the request
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    @(negedge i_core_clk);
    d = i_rvalid ? i_rdata : 16'hxxxx;
  endtask
  task automatic frames(input int n, input int half);
    repeat (n) begin
      @(posedge i_core_clk);
      o_in_lrclk <= 1'b1;
      repeat (half) @(posedge i_core_clk);
      o_in_lrclk <= 1'b0;
      repeat (half) @(posedge i_core_clk);
    end
  endtask
  task automatic opulse(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_out_lrclk <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      o_out_lrclk <= 1'b0;
      repeat (10) @(posedge i_core_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** verification/test_dcc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_dcc_core;
  localparam logic [11:0] CTL = dcc_pkg::CORE_CTL_ADDR;
  localparam logic [11:0] SLA = dcc_pkg::SL_ADDR_BASE;
  localparam logic [11:0] SLD = dcc_pkg::SL_DATA_BASE;
  logic i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_in_lrclk, i_out_lrclk;
  logic [11:0] i_reg_addr;
  logic [10:0] o_pc, pc_d, pc_end;
  logic [33:0] i_reg_wdata, o_sl_data;
  logic [15:0] o_reg_rdata, d;
  logic [12:0] i_dm_base, o_dm_addr, o_dm_fill_addr, fill_last, a0;
  logic [9:0] o_sl_addr;
  logic [5:0] o_slew_idx;
  logic o_reg_rvalid, o_frame_start, o_prog_end, o_out_latch, o_core_clear_n, o_mult_zero;
  logic o_in_port_zero, o_dm_fill_we, o_slew_we, o_slew_zero, o_sl_we, o_sl_to_target, slew_z;
  logic [44:0] slq[$];
  int fail_count, check_count, fs_n, pe_n, ol_n, fill_n, slew_n, n0, n1;
  dcc_core dcc_core_i (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .i_in_lrclk(i_in_lrclk),
    .i_out_lrclk(i_out_lrclk),
    .o_pc(o_pc),
    .o_frame_start(o_frame_start),
    .o_prog_end(o_prog_end),
    .o_out_latch(o_out_latch),
    .o_core_clear_n(o_core_clear_n),
    .o_mult_zero(o_mult_zero),
    .o_in_port_zero(o_in_port_zero),
    .i_dm_base(i_dm_base),
    .o_dm_addr(o_dm_addr),
    .o_dm_fill_we(o_dm_fill_we),
    .o_dm_fill_addr(o_dm_fill_addr),
    .o_slew_we(o_slew_we),
    .o_slew_idx(o_slew_idx),
    .o_slew_zero(o_slew_zero),
    .o_sl_we(o_sl_we),
    .o_sl_to_target(o_sl_to_target),
    .o_sl_addr(o_sl_addr),
    .o_sl_data(o_sl_data)
  );
  dcc_host dcc_host_i (.i_core_clk(i_core_clk), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata),
    .o_in_lrclk(i_in_lrclk), .o_out_lrclk(i_out_lrclk));
  always @(posedge i_core_clk) begin
    pc_d <= o_pc;
    if (o_frame_start) pc_end <= pc_d;
    fs_n += o_frame_start;
    pe_n += o_prog_end;
    ol_n += o_out_latch;
    fill_n += o_dm_fill_we;
    slew_n += o_slew_we;
    if (o_dm_fill_we) fill_last <= o_dm_fill_addr;
    if (o_slew_we) slew_z <= o_slew_zero;
    if (o_sl_we) slq.push_back({o_sl_to_target, o_sl_addr, o_sl_data});
  end
  task automatic chk(input string what, input logic [44:0] seen, input logic [44:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task automatic setb(input logic [12:0] v);
    @(posedge i_core_clk);
    i_dm_base <= v;
    settle(1);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (90000) @(posedge i_core_clk);
    fail_count++;
    close_out();
  end
  initial begin
    i_rst_n = 1'b0;
    i_dm_base = 13'h0000;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    dcc_host_i.rd(CTL, d);
    chk("ctl reset", d, 16'h0000);
    chk("clear reset", o_core_clear_n, 1'b0);
    dcc_host_i.rd(dcc_pkg::RAM_CFG_ADDR, d);
    chk("cfg reset", d, 16'h000c);
    dcc_host_i.rd(12'h0700, d);
    chk("unmapped", d, 16'h0000);
    dcc_host_i.wr(CTL, 34'h0340);
    settle(0);
    chk("clear_n", o_core_clear_n, 1'b1);
    chk("mult zero", o_mult_zero, 1'b1);
    chk("in zero", o_in_port_zero, 1'b1);
    dcc_host_i.wr(CTL, 34'h0200);
    settle(0);
    chk("mult run", o_mult_zero, 1'b0);
    chk("in run", o_in_port_zero, 1'b0);
    n0 = slew_n;
    // volume ramps down before the core is shut down, avoiding a click
    dcc_host_i.wr(CTL, 34'h1200);
    settle(80);
    chk("mute walk", slew_n - n0, 64);
    chk("mute level", slew_z, 1'b1);
    dcc_host_i.rd(CTL, d);
    chk("muted flag", d, 16'h3200);
    dcc_host_i.rd(CTL, d);
    chk("flag cleared", d, 16'h1200);
    dcc_host_i.wr(CTL, 34'h1000);
    settle(0);
    chk("shutdown", o_core_clear_n, 1'b0);
    n0 = slew_n;
    dcc_host_i.wr(CTL, 34'h0200);
    settle(80);
    chk("restore walk", slew_n - n0, 64);
    chk("restore level", slew_z, 1'b0);
    dcc_host_i.rd(CTL, d);
    chk("no flag", d, 16'h0200);
    n0 = fill_n;
    dcc_host_i.wr(CTL, 34'h0280);
    settle(6200);
    chk("fill count", fill_n - n0, 6144);
    chk("fill last", fill_last, 13'h17ff);
    dcc_host_i.rd(CTL, d);
    chk("fill done", d, 16'h0200);
    for (int c = 0; c < 4; c++) begin
      dcc_host_i.wr(CTL, 34'h0200 | c);
      settle(0);
      n0 = pe_n;
      n1 = ol_n;
      dcc_host_i.frames(2, 1000);
      settle(0);
      chk("length", pc_end, (1536 >> c) - 1);
      chk("ends", pe_n - n0, 2);
      chk("latches", ol_n - n1, 2);
    end
    for (int s = 0; s < 4; s++) begin
      dcc_host_i.wr(CTL, 34'h0203 | (s << 2));
      settle(0);
      n0 = fs_n;
      dcc_host_i.frames(8, 150);
      settle(0);
      chk("syncs", fs_n - n0, 8 >> s);
    end
    dcc_host_i.wr(CTL, 34'h0603);
    settle(0);
    n0 = ol_n;
    dcc_host_i.opulse(3);
    settle(0);
    chk("lr latches", ol_n - n0, 3);
    dcc_host_i.wr(SLA, 34'h0000);
    dcc_host_i.wr(SLD, 34'h2_1234_5678);
    dcc_host_i.wr(SLA + 12'h002, 34'h0155);
    dcc_host_i.wr(SLD + 12'h002, 34'h1_0bad_cafe);
    dcc_host_i.wr(CTL, 34'h0223);
    slq.delete();
    dcc_host_i.frames(1, 150);
    settle(0);
    chk("sl count", slq.size(), 2);
    chk("sl first", slq[0], {1'b1, 10'h000, 34'h2_1234_5678});
    chk("sl third", slq[1], {1'b1, 10'h155, 34'h1_0bad_cafe});
    dcc_host_i.rd(CTL, d);
    chk("target done", d, 16'h0203);
    dcc_host_i.wr(SLA + 12'h001, 34'h0007);
    dcc_host_i.wr(SLD + 12'h001, 34'habcd);
    dcc_host_i.wr(CTL, 34'h0213);
    slq.delete();
    dcc_host_i.frames(1, 150);
    settle(0);
    chk("sl one", slq.size(), 1);
    chk("sl param", slq[0], {1'b0, 10'h007, 34'habcd});
    dcc_host_i.rd(CTL, d);
    chk("param done", d, 16'h0203);
    dcc_host_i.wr(dcc_pkg::RAM_CFG_ADDR, 34'h0001);
    dcc_host_i.rd(dcc_pkg::RAM_CFG_ADDR, d);
    chk("cfg", d, 16'h0001);
    setb(13'h0000);
    a0 = o_dm_addr;
    setb(13'h01ff);
    chk("wrap", o_dm_addr, (a0 + 511) % 512);
    setb(13'h0258);
    chk("direct", o_dm_addr, 13'h0258);
    dcc_host_i.frames(1, 150);
    setb(13'h0000);
    chk("advance", o_dm_addr, (a0 + 1) % 512);
    close_out();
  end
endmodule
`default_nettype wire
